// File: hw/i2cmcd_pkg.sv
package i2cmcd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] MSA_OFFSET = 8'h00;
  localparam logic [7:0] MCS_OFFSET = 8'h04;
  localparam logic [7:0] MDR_OFFSET = 8'h08;

  // reset values
  localparam logic [7:0] MSA_RESET = 8'h00;
  localparam logic [7:0] MDR_RESET = 8'h00;

  // field positions
  localparam int MSA_DIR_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERROR_BIT = 1;
  localparam int ST_ADRACK_BIT = 2;
  localparam int ST_DATACK_BIT = 3;
  localparam int ST_IDLE_BIT = 5;
  localparam int ST_BUSBSY_BIT = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SCL_PERIOD_NS = 200; // forty clocks, the bit timer's reset setting
  // one bit time is split into four quarters; each quarter rounds down
  localparam int QTR_CYCLES = (SCL_PERIOD_NS * 1000) / (4 * CLK_PERIOD_PS);
  localparam logic [9:0] QTR_LAST = 10'(QTR_CYCLES - 1);
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // control write, low four bits of the data word
  typedef struct packed {
    logic ack;
    logic stop;
    logic start;
    logic run;
  } i2cmcd_ctrl_type;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_TX = 2'b01,
    MS_RX = 2'b10
  } i2cmcd_mstate_type;

  typedef enum logic [2:0] {
    EN_IDLE = 3'b000,
    EN_START = 3'b001,
    EN_ADDR = 3'b010,
    EN_DATA = 3'b011,
    EN_STOP = 3'b100
  } i2cmcd_eng_type;

  // decoded bus action
  typedef struct packed {
    logic valid;
    logic do_start;
    logic do_data;
    logic is_rx;
    logic ack;
    logic do_stop;
    i2cmcd_mstate_type next_state;
  } i2cmcd_act_type;

endpackage

// File: hw/i2cmcd_top.sv
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
// Summary of operation
// - control bit 0 enables the master to send or receive
// - idle, send, start+run: start, send byte, go to transmit state
// - idle, send, start+stop+run: start, send byte, stop, stay idle
// - idle, receive, no ack, start+run: start, receive with nack, go receive
// - idle, receive, no ack, start+stop+run: start, receive, stop, stay idle
// - idle, receive, ack, start+run: start, receive with ack, go receive
// - transmit, run only: send next byte, stay in transmit
// - transmit or receive, stop only: stop condition, back to idle
// - transmit, stop+run: send one more byte, stop, go idle
// - transmit, send, start+run: repeated start, send; stop bit picks idle
// - transmit, receive, no ack, start+run: repeated start, receive nack, go receive
// - transmit, receive, no ack, start+stop+run: repeated start, send, stop, idle
// - transmit, receive, ack, start+run: repeated start, receive ack, go receive
// - receive, run only, no ack: receive with nack, stay
// - receive, stop+run, no ack: final receive, stop, go idle
// - receive, ack, run only: receive with ack, stay
// - receive, receive dir, start+run: repeated start, receive; ack/stop pick outcome
// - receive, send dir, start+run: repeated start, send; stop picks idle or transmit
// - address bit 0 picks receive when set, send when clear
// - with ack enable set, received bytes are acknowledged by the master
module i2cmcd_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import i2cmcd_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] msa_reg, tx_data_reg, rx_data_reg, shift_reg;
  logic [31:0] rdata_reg;
  logic [1:0] scl_sync_reg, sda_sync_reg, q_reg;
  logic sda_prev_reg, bus_busy_reg, scl_oe_reg, sda_oe_reg, hold_reg, adrack_reg, datack_reg;
  logic [9:0] div_reg;
  logic [3:0] bit_reg;
  i2cmcd_eng_type eng_state;
  i2cmcd_mstate_type mstate;
  i2cmcd_act_type act, job_reg;
  i2cmcd_ctrl_type ctrl;
  logic tick, stall, ctrl_wr, dir, scl_s, sda_s, bit_tx;

  assign ctrl = i2cmcd_ctrl_type'(wdata[3:0]);
  assign dir = msa_reg[MSA_DIR_BIT];
  // control writes that land while the engine runs are dropped, not queued
  assign ctrl_wr = wr && (addr == MCS_OFFSET) && (eng_state == EN_IDLE);
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];

  // ----------------------------------------------------------------
  // command decoder
  // ----------------------------------------------------------------
  // one table per master state; anything unmatched stays a nop
  always_comb begin
    act = '0;
    act.next_state = mstate;
    unique case (mstate)
      MS_IDLE: begin
        if (ctrl.run && ctrl.start) begin
          if (!dir) begin
            act = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, ctrl.stop, ctrl.stop ? MS_IDLE : MS_TX};
          end else if (!ctrl.ack) begin
            act = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, ctrl.stop, ctrl.stop ? MS_IDLE : MS_RX};
          end else if (!ctrl.stop) begin
            act = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, MS_RX};
          end
        end
      end
      MS_TX: begin
        if (!ctrl.start && ctrl.stop && !ctrl.run) begin
          act = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, MS_IDLE};
        end else if (!ctrl.start && ctrl.run) begin
          act = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, ctrl.stop, ctrl.stop ? MS_IDLE : MS_TX};
        end else if (ctrl.start && ctrl.run) begin
          if (!dir) begin
            act = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, ctrl.stop, ctrl.stop ? MS_IDLE : MS_TX};
          end else if (!ctrl.ack && ctrl.stop) begin
            // receive direction still sends a byte here, then stops
            act = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, MS_IDLE};
          end else if (!ctrl.stop) begin
            act = '{1'b1, 1'b1, 1'b1, 1'b1, ctrl.ack, 1'b0, MS_RX};
          end
        end
      end
      MS_RX: begin
        // stop here is expected only after a nack
        if (!ctrl.start && ctrl.stop && !ctrl.run) begin
          act = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, MS_IDLE};
        end else if (!ctrl.start && ctrl.run && !(ctrl.ack && ctrl.stop)) begin
          act = '{1'b1, 1'b0, 1'b1, 1'b1, ctrl.ack, ctrl.stop, ctrl.stop ? MS_IDLE : MS_RX};
        end else if (ctrl.start && ctrl.run) begin
          if (!dir) begin
            act = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, ctrl.stop, ctrl.stop ? MS_IDLE : MS_TX};
          end else if (!(ctrl.ack && ctrl.stop)) begin
            act = '{1'b1, 1'b1, 1'b1, 1'b1, ctrl.ack, ctrl.stop, ctrl.stop ? MS_IDLE : MS_RX};
          end
        end
      end
      default: begin
        act = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  // software writable registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      msa_reg <= MSA_RESET;
      tx_data_reg <= MDR_RESET;
    end else if (wr) begin
      if (addr == MSA_OFFSET) begin
        msa_reg <= wdata[7:0];
      end
      if (addr == MDR_OFFSET) begin
        tx_data_reg <= wdata[7:0];
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (rd) begin
      unique case (addr)
        MSA_OFFSET: rdata_reg <= {24'h000000, msa_reg};
        MDR_OFFSET: rdata_reg <= {24'h000000, rx_data_reg};
        MCS_OFFSET: begin
          rdata_reg <= '0;
          rdata_reg[ST_BUSY_BIT] <= (eng_state != EN_IDLE);
          rdata_reg[ST_ERROR_BIT] <= adrack_reg | datack_reg;
          rdata_reg[ST_ADRACK_BIT] <= adrack_reg;
          rdata_reg[ST_DATACK_BIT] <= datack_reg;
          rdata_reg[ST_IDLE_BIT] <= (mstate == MS_IDLE) && (eng_state == EN_IDLE);
          rdata_reg[ST_BUSBSY_BIT] <= bus_busy_reg;
        end
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and bus busy tracking
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      sda_prev_reg <= 1'b1;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      sda_prev_reg <= sda_s;
      scl_out <= 1'b0; // open drain: only the enables ever move
      sda_out <= 1'b0;
    end
  end

  // start and stop seen on the wire, whoever made them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_busy_reg <= 1'b0;
    end else if (scl_s && sda_prev_reg && !sda_s) begin
      bus_busy_reg <= 1'b1;
    end else if (scl_s && !sda_prev_reg && sda_s) begin
      bus_busy_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // quarter bit timer
  // ----------------------------------------------------------------
  // a slave holding the clock low freezes the timer (clock stretching)
  assign stall = (eng_state != EN_IDLE) && !scl_oe_reg && !scl_s;
  assign tick = (div_reg == QTR_LAST) && !stall;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (eng_state == EN_IDLE || tick) begin
      div_reg <= '0;
    end else if (!stall) begin
      div_reg <= div_reg + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // master state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mstate <= MS_IDLE;
    end else if (ctrl_wr && act.valid) begin
      mstate <= act.next_state;
    end
  end

  // ----------------------------------------------------------------
  // bus engine
  // ----------------------------------------------------------------
  // bit sent in quarter one: address/transmit data, or our ack bit
  always_comb begin
    if (bit_reg == ACK_BIT_IDX) begin
      bit_tx = (eng_state == EN_DATA) && job_reg.is_rx && job_reg.ack;
    end else begin
      bit_tx = (eng_state == EN_ADDR || !job_reg.is_rx) && !shift_reg[7];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_state <= EN_IDLE;
      job_reg <= '0;
      q_reg <= 2'b00;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      hold_reg <= 1'b0;
      adrack_reg <= 1'b0;
      datack_reg <= 1'b0;
      rx_data_reg <= MDR_RESET;
    end else if (eng_state == EN_IDLE) begin
      q_reg <= 2'b00;
      bit_reg <= 4'h0;
      if (ctrl_wr && act.valid) begin
        job_reg <= act;
        adrack_reg <= 1'b0;
        datack_reg <= 1'b0;
        if (act.do_start) begin
          eng_state <= EN_START;
          shift_reg <= {msa_reg[7:1], dir};
        end else if (act.do_data) begin
          eng_state <= EN_DATA;
          shift_reg <= act.is_rx ? 8'hFF : tx_data_reg;
        end else begin
          eng_state <= EN_STOP;
        end
      end
    end else if (tick) begin
      q_reg <= q_reg + 2'b01;
      unique case (eng_state)
        EN_START: begin
          // q0 keeps the clock low only if we already hold it (repeated start)
          unique case (q_reg)
            2'b00: begin
              scl_oe_reg <= hold_reg;
              sda_oe_reg <= 1'b0;
            end
            2'b01: scl_oe_reg <= 1'b0;
            2'b10: sda_oe_reg <= 1'b1;
            2'b11: eng_state <= EN_ADDR;
          endcase
        end
        EN_ADDR, EN_DATA: begin
          unique case (q_reg)
            2'b00: scl_oe_reg <= 1'b1;
            2'b01: sda_oe_reg <= bit_tx;
            2'b10: scl_oe_reg <= 1'b0;
            2'b11: begin
              scl_oe_reg <= 1'b1;
              hold_reg <= 1'b1;
              if (bit_reg != ACK_BIT_IDX) begin
                shift_reg <= {shift_reg[6:0], sda_s};
                bit_reg <= bit_reg + 4'h1;
              end else begin
                bit_reg <= 4'h0;
                if (eng_state == EN_ADDR) begin
                  adrack_reg <= sda_s;
                  if (sda_s) begin
                    // address refused: skip the data byte
                    eng_state <= job_reg.do_stop ? EN_STOP : EN_IDLE;
                  end else begin
                    eng_state <= EN_DATA;
                    shift_reg <= job_reg.is_rx ? 8'hFF : tx_data_reg;
                  end
                end else begin
                  if (job_reg.is_rx) begin
                    rx_data_reg <= shift_reg;
                  end else begin
                    datack_reg <= sda_s;
                  end
                  eng_state <= job_reg.do_stop ? EN_STOP : EN_IDLE;
                end
              end
            end
          endcase
        end
        EN_STOP: begin
          unique case (q_reg)
            2'b00: begin
              scl_oe_reg <= 1'b1;
              sda_oe_reg <= 1'b1;
            end
            2'b01: scl_oe_reg <= 1'b0;
            2'b10: sda_oe_reg <= 1'b0;
            2'b11: begin
              hold_reg <= 1'b0;
              eng_state <= EN_IDLE;
            end
          endcase
        end
        default: eng_state <= EN_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // ports read the flops directly; the constant low levels sit with the synchronisers
  assign rdata = rdata_reg;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  run_gate_a: assert property (
    (ctrl_wr && !ctrl.run && !ctrl.stop) |=> (eng_state == EN_IDLE))
    else $error("engine left idle without run");
  idle_send_a: assert property (
    (ctrl_wr && mstate == MS_IDLE && !dir && wdata[3:0] == 4'h3)
      |=> (mstate == MS_TX && eng_state == EN_START && !job_reg.is_rx))
    else $error("idle start send mishandled");
  idle_sendstop_a: assert property (
    (ctrl_wr && mstate == MS_IDLE && !dir && wdata[2:0] == 3'h7)
      |=> (mstate == MS_IDLE && job_reg.do_stop && eng_state == EN_START))
    else $error("idle send stop mishandled");
  idle_rxnack_a: assert property (
    (ctrl_wr && mstate == MS_IDLE && dir && wdata[3:0] == 4'h3)
      |=> (mstate == MS_RX && job_reg.is_rx && !job_reg.ack))
    else $error("idle receive nack mishandled");
  idle_rxstop_a: assert property (
    (ctrl_wr && mstate == MS_IDLE && dir && wdata[3:0] == 4'h7)
      |=> (mstate == MS_IDLE && job_reg.is_rx && job_reg.do_stop))
    else $error("idle receive stop mishandled");
  idle_rxack_a: assert property (
    (ctrl_wr && mstate == MS_IDLE && dir && wdata[3:0] == 4'hB)
      |=> (mstate == MS_RX && job_reg.ack))
    else $error("idle receive ack mishandled");
  tx_next_a: assert property (
    (ctrl_wr && mstate == MS_TX && wdata[2:0] == 3'h1)
      |=> (mstate == MS_TX && eng_state == EN_DATA))
    else $error("transmit continue mishandled");
  stop_only_a: assert property (
    (ctrl_wr && mstate != MS_IDLE && wdata[2:0] == 3'h4)
      |=> (mstate == MS_IDLE && eng_state == EN_STOP))
    else $error("stop only mishandled");
  tx_sendstop_a: assert property (
    (ctrl_wr && mstate == MS_TX && wdata[2:0] == 3'h5)
      |=> (eng_state == EN_DATA && job_reg.do_stop && mstate == MS_IDLE))
    else $error("send then stop mishandled");
  rs_odd_a: assert property (
    (ctrl_wr && mstate == MS_TX && dir && wdata[3:0] == 4'h7)
      |=> (eng_state == EN_START && !job_reg.is_rx && mstate == MS_IDLE))
    else $error("repeated start send stop mishandled");
  rx_keep_a: assert property (
    (ctrl_wr && mstate == MS_RX && wdata[3:0] == 4'h9)
      |=> (mstate == MS_RX && eng_state == EN_DATA && job_reg.ack))
    else $error("receive ack continue mishandled");
  illegal_nop_a: assert property (
    (ctrl_wr && mstate == MS_RX && wdata[3:0] == 4'hD) |=> (eng_state == EN_IDLE && mstate == MS_RX))
    else $error("illegal code reached the bus");
  ack_drive_a: assert property (
    (eng_state == EN_DATA && job_reg.is_rx && bit_reg == ACK_BIT_IDX && q_reg >= 2'b10)
      |-> (sda_oe_reg == job_reg.ack))
    else $error("receive acknowledge level wrong");
  start_seq_a: assert property (
    (eng_state == EN_START && tick && q_reg == 2'b10) |=> (sda_oe_reg && scl_s ##1 eng_state == EN_START))
    else $error("start edge taken with clock low");

endmodule

// File: verif/i2cmcd_slave_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// far side: one slave on an open-drain two-wire bus
// ----------------------------------------------------------------
module i2cmcd_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic addr_ack,
  input wire logic data_ack,
  input wire logic [7:0] rd_byte,
  output logic sda_oe
);
  int bitn = 0;
  int nbyte = 0;
  int starts = 0;
  int stops = 0;
  logic [7:0] sh = 8'h00;
  logic reading = 1'b0;
  logic mnack = 1'b0;
  logic [7:0] got_q[$];
  logic mack_q[$];

  initial sda_oe = 1'b0;

  // start or repeated start opens a new frame
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      starts++;
      bitn = 0;
      nbyte = 0;
      reading = 1'b0;
      mnack = 1'b0;
    end
  end

  // stop ends the frame; the line is already released
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      stops++;
      bitn = 0;
      reading = 1'b0;
    end
  end

  // sample on rising clock: data bits, then the master's answer on reads
  always @(posedge scl) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
    end else if (reading && nbyte > 0) begin
      mack_q.push_back(sda);
      mnack = sda;
    end
    bitn++;
  end

  // drive on falling clock only, so the line never moves while the clock is high
  always @(negedge scl) begin
    if (bitn == 8) begin
      if (nbyte == 0) begin
        got_q.push_back(sh);
        reading = sh[0] && addr_ack;
        sda_oe <= addr_ack;
      end else if (!reading) begin
        got_q.push_back(sh);
        sda_oe <= data_ack;
      end else begin
        sda_oe <= 1'b0;
      end
    end else if (bitn == 9) begin
      bitn = 0;
      nbyte++;
      // a negative answer from the master means no further byte is offered
      sda_oe <= reading && !mnack && !rd_byte[7];
    end else begin
      sda_oe <= reading && nbyte > 0 && !mnack && !rd_byte[7 - bitn];
    end
  end
endmodule

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import i2cmcd_pkg::*;
  logic ref_clk, rst_n, wr, rd, scl_out, scl_oe, sda_out, sda_oe, scl, sda, s_oe, adr_ok, dat_ok;
  logic [7:0] addr, rd_byte, sla, txb;
  logic [31:0] wdata, rdata, s, seed;
  int mismatches, check_count, mstate, n_start, n_stop;
  logic [7:0] exp_q[$];

  // open-drain wires with pull-ups
  assign scl = scl_oe ? scl_out : 1'b1;
  assign sda = (sda_oe ? sda_out : 1'b1) & ~s_oe;

  i2cmcd_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe));
  i2cmcd_slave_model slv (.scl(scl), .sda(sda), .addr_ack(adr_ok), .data_ack(dat_ok), .rd_byte(rd_byte),
    .sda_oe(s_oe));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // reference decode: -1 for no-op, else bit0 start, bit1 data, bit2 receive, bit3 stop, bits5:4 next state
  function automatic int dec(input int st, input logic dir, input logic [3:0] c);
    int d, a, p;
    d = int'(dir);
    a = int'(c[3]);
    p = int'(c[2]);
    if (!c[0]) return (st != 0 && c[2] && !c[1]) ? 8 : -1;
    if (c[1]) begin
      if (d == 1 && a == 1 && p == 1) return -1;
      if (d == 1 && st == 1 && p == 1) return 11;
      return 3 + 4 * d + 8 * p + 16 * (p == 1 ? 0 : (d == 1 ? 2 : 1));
    end
    if (st == 0 || (st == 2 && a == 1 && p == 1)) return -1;
    return 2 + 4 * (st == 2) + 8 * p + 16 * (p == 1 ? 0 : st);
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    d = rdata;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // every unlisted or illegal code in state st must leave bus, state and engine alone
  task automatic nops(input int st, input string name, input logic [31:0] exp, input logic [31:0] msk);
    for (int k = 0; k < 32; k++) begin
      if (dec(st, k[4], k[3:0]) == -1) begin
        wr_reg(MSA_OFFSET, {31'h0, k[4]});
        wr_reg(MCS_OFFSET, {28'h0000000, k[3:0]});
        rd_reg(MCS_OFFSET, s);
        check(name, exp, s & msk);
      end
    end
    wr_reg(MSA_OFFSET, {24'h000000, sla});
    $display("test %s done", name);
  endtask

  // issue one control word, wait for the engine, compare bus and status with the model
  task automatic run_cmd(input string name, input logic [3:0] c, input logic poke);
    int r, n;
    logic [31:0] e;
    r = dec(mstate, sla[0], c);
    wr_reg(MCS_OFFSET, {28'h0000000, c});
    rd_reg(MCS_OFFSET, s);
    check({name, " busy"}, 32'h00000001, s & 32'h00000001);
    // a control write while busy must be dropped
    if (poke) wr_reg(MCS_OFFSET, 32'h00000007);
    n = 0;
    while (s[ST_BUSY_BIT] !== 1'b0 && n < 500) begin
      repeat (20) @(posedge ref_clk);
      rd_reg(MCS_OFFSET, s);
      n++;
    end
    if (r[0]) begin
      n_start++;
      exp_q.push_back(sla);
    end
    if (r[1] && !r[2] && (!r[0] || adr_ok)) exp_q.push_back(txb);
    n_stop += r[3];
    e = 32'h00000000;
    e[ST_IDLE_BIT] = (r[5:4] == 0);
    e[ST_BUSBSY_BIT] = (r[5:4] != 0);
    e[ST_ADRACK_BIT] = r[0] && !adr_ok;
    e[ST_DATACK_BIT] = r[1] && !r[2] && (!r[0] || adr_ok) && !dat_ok;
    e[ST_ERROR_BIT] = e[ST_ADRACK_BIT] | e[ST_DATACK_BIT];
    check({name, " status"}, e, s);
    check({name, " starts"}, n_start, slv.starts);
    check({name, " stops"}, n_stop, slv.stops);
    check({name, " bytes"}, exp_q.size(), slv.got_q.size());
    for (int k = 0; k < exp_q.size() && k < slv.got_q.size(); k++) check({name, " byte"}, exp_q[k], slv.got_q[k]);
    if (r[2] && adr_ok) begin
      rd_reg(MDR_OFFSET, s);
      check({name, " rx data"}, {24'h000000, rd_byte}, s);
      check({name, " master ack"}, {31'h0, ~c[3]}, {31'h0, slv.mack_q[$]});
    end
    mstate = r[5:4];
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {wr, rd, adr_ok, dat_ok} = 4'h3;
    {addr, rd_byte, sla, txb} = 32'h00000000;
    wdata = 32'h00000000;
    seed = 32'h4611cb91;
    {mismatches, check_count, mstate} = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    n_start = slv.starts;
    n_stop = slv.stops;
    rd_reg(MSA_OFFSET, s);
    check("msa reset", {24'h000000, MSA_RESET}, s);
    rd_reg(MDR_OFFSET, s);
    check("mdr reset", {24'h000000, MDR_RESET}, s);
    rd_reg(MCS_OFFSET, s);
    check("status reset", 32'h00000020, s);
    rd_reg(8'h0C, s);
    check("unmapped read", 32'h00000000, s);
    nops(0, "idle nop", 32'h00000020, 32'hFFFFFFFF);
    seed = lfsr(seed);
    {rd_byte, txb, sla} = {seed[23:8], seed[7:1], 1'b0};
    wr_reg(MSA_OFFSET, {24'h000000, sla});
    wr_reg(MDR_OFFSET, {24'h000000, txb});
    adr_ok = 1'b0;
    run_cmd("send addr nack", 4'h3, 1'b0);
    // in transmit, unlisted codes keep the state and the engine idle
    nops(1, "transmit nop", 32'h00000000, 32'h00000021);
    adr_ok = 1'b1;
    run_cmd("send next", 4'h1, 1'b0);
    run_cmd("stop only", 4'h4, 1'b0);
    seed = lfsr(seed);
    {rd_byte, txb, sla} = {seed[23:8], seed[7:1], 1'b1};
    wr_reg(MSA_OFFSET, {24'h000000, sla});
    run_cmd("receive ack", 4'hB, 1'b0);
    run_cmd("receive more", 4'h9, 1'b0);
    nops(2, "receive nop", 32'h00000000, 32'h00000021);
    // negative answer on the last byte before stop, as software must do
    run_cmd("receive last", 4'h5, 1'b0);
    run_cmd("receive stop", 4'h7, 1'b0);
    seed = lfsr(seed);
    {rd_byte, txb, sla} = {seed[23:8], seed[7:1], 1'b0};
    wr_reg(MSA_OFFSET, {24'h000000, sla});
    wr_reg(MDR_OFFSET, {24'h000000, txb});
    run_cmd("send start", 4'h3, 1'b0);
    run_cmd("send more stop", 4'h5, 1'b0);
    dat_ok = 1'b0;
    run_cmd("send stop", 4'hF, 1'b1);
    complete_run();
  end

  // watchdog: ten transfers of under a thousand cycles plus three nop sweeps fit well inside
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    $display("[ERR] watchdog expected done seen hang");
    complete_run();
  end
endmodule
